// File: lkt_pkg.sv
// constants and types shared by the link test and error monitor
package lkt_pkg;
  localparam logic [11:0] A_LINK_PAGE = 12'h300;
  localparam logic [11:0] A_PRBS_EN   = 12'h315;
  localparam logic [11:0] A_PRBS_CTL  = 12'h316;
  localparam logic [11:0] A_PRBS_THR0 = 12'h317;
  localparam logic [11:0] A_PRBS_THR1 = 12'h318;
  localparam logic [11:0] A_PRBS_THR2 = 12'h319;
  localparam logic [11:0] A_PRBS_CNT0 = 12'h31A;
  localparam logic [11:0] A_PRBS_CNT1 = 12'h31B;
  localparam logic [11:0] A_PRBS_CNT2 = 12'h31C;
  localparam logic [11:0] A_PRBS_PASS = 12'h31D;
  localparam logic [11:0] A_TPL_CTL   = 12'h32C;
  localparam logic [11:0] A_TPL_EXP_A = 12'h32D;
  localparam logic [11:0] A_TPL_EXP_B = 12'h32E;
  localparam logic [11:0] A_TPL_FAIL  = 12'h32F;
  localparam logic [11:0] A_ERR_VIEW  = 12'h46B;
  localparam logic [11:0] A_OVER_DISP = 12'h46D;
  localparam logic [11:0] A_OVER_NIT  = 12'h46E;
  localparam logic [11:0] A_OVER_UCC  = 12'h46F;
  localparam logic [11:0] A_CGS_PASS  = 12'h470;
  localparam logic [11:0] A_ILAS_PASS = 12'h473;
  localparam logic [11:0] A_TEST_CFG  = 12'h477;
  localparam logic [11:0] A_ERR_THR   = 12'h47C;
  // field positions
  localparam int B_LINK_SEL  = 2;
  localparam int B_PRBS_CLR  = 0;
  localparam int B_PRBS_RUN  = 1;
  localparam int F_POLY_LO   = 2;
  localparam int F_PLANE_LO  = 4;
  localparam int B_TPL_EN    = 0;
  localparam int B_TPL_CLR   = 1;
  localparam int F_CONV_LO   = 2;
  localparam int F_SAMP_LO   = 4;
  localparam int F_VLANE_LO  = 4;
  localparam int B_ILAS_TEST = 7;
  localparam int B_RST_IRQ   = 7;
  localparam int B_DIS_CNT   = 6;
  localparam int B_RST_CNT   = 5;
  localparam int TPL_RES11_LO = 5;
  // reset values
  localparam logic [7:0] R_ZERO    = 8'h00;
  localparam logic [7:0] R_ERR_THR = 8'hFF;
  // pattern lengths and limits
  localparam logic [4:0] LEN_PRBS7  = 5'h07;
  localparam logic [4:0] LEN_PRBS15 = 5'h0F;
  localparam logic [4:0] LEN_PRBS31 = 5'h1F;
  localparam logic [23:0] TALLY_MAX = 24'hFFFFFF;
  localparam logic [2:0] CGS_COMMAS = 3'h4;
  localparam logic [2:0] LINK1_OFFSET = 3'h4;
  typedef enum logic [1:0] {
    LKT_PRBS7  = 2'h0,
    LKT_PRBS15 = 2'h1,
    LKT_PRBS31 = 2'h2
  } lkt_poly_e;
  typedef enum logic [1:0] {
    LKT_CNT_DISP = 2'h0,
    LKT_CNT_NIT  = 2'h1,
    LKT_CNT_UCC  = 2'h2
  } lkt_cnt_e;
  typedef enum logic [1:0] {
    LKT_IDLE = 2'b01,
    LKT_RUN  = 2'b10
  } lkt_run_e;
endpackage

// File: lkt_if.sv
// carriers between the top and its lane checkers and error counters
`timescale 1ns/1ps
interface lkt_prbs_if;
  logic        clear;
  logic        run;
  logic [1:0]  poly;
  logic        en;
  logic        rx_bit;
  logic [23:0] tally;
  modport chk (input clear, input run, input poly, input en, input rx_bit, output tally);
  modport ctl (output clear, output run, output poly, output en, output rx_bit, input tally);
endinterface

interface lkt_cnt_if;
  logic       err;
  logic [7:0] thr;
  logic       sel;
  logic       rst_irq;
  logic       dis;
  logic       rst_cnt;
  logic [7:0] count;
  logic       reached;
  modport cnt (input err, input thr, input sel, input rst_irq, input dis, input rst_cnt,
               output count, output reached);
  modport ctl (output err, output thr, output sel, output rst_irq, output dis, output rst_cnt,
               input count, input reached);
endinterface

// File: lkt_prbs_checker.sv
// self-synchronising pattern checker for one physical lane
`timescale 1ns/1ps
module lkt_prbs_checker
  import lkt_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  lkt_prbs_if.chk  p
);
  logic [30:0] shift;
  logic [4:0]  fill;
  logic [4:0]  len;
  logic        pred;

  always_comb
  begin
    unique case (p.poly)
      LKT_PRBS15:
      begin
        len  = LEN_PRBS15;
        pred = shift[14] ^ shift[13];
      end
      LKT_PRBS31:
      begin
        len  = LEN_PRBS31;
        pred = shift[30] ^ shift[27];
      end
      default:
      begin
        len  = LEN_PRBS7;
        pred = shift[6] ^ shift[5];
      end
    endcase
  end

  // no link establishment needed, runs on raw lane bits
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      shift   <= '0;
      fill    <= '0;
      p.tally <= '0;
    end
    else if (p.clear)
    begin
      shift   <= '0;
      fill    <= '0;
      p.tally <= '0;
    end
    else if (p.en)
    begin
      shift <= {shift[29:0], p.rx_bit};
      if (fill < len)
        fill <= fill + 5'h01;
      else if (p.run && (p.rx_bit != pred) && (p.tally != TALLY_MAX))
        p.tally <= p.tally + 24'h000001;
    end
  end
endmodule

// File: lkt_err_counter.sv
// one per-lane per-type character error counter with threshold flag
`timescale 1ns/1ps
module lkt_err_counter
  import lkt_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  lkt_cnt_if.cnt   c
);
  logic disabled;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      c.count  <= '0;
      disabled <= 1'b0;
    end
    else
    begin
      if (c.sel)
        disabled <= c.dis;
      if (c.sel && c.rst_cnt)
        c.count <= '0;
      else if (c.err && !disabled && (c.count < c.thr))
        c.count <= c.count + 8'h01;
    end
  end

  // threshold flag, a new hit beats the clear
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      c.reached <= 1'b0;
    else
      c.reached <= (c.reached & ~(c.sel & c.rst_irq)) | (c.count >= c.thr);
  end
endmodule

// File: lkt_link_test.sv
// link test and error monitor top with byte register port
`timescale 1ns/1ps
// Summary of operation
// - pattern checker runs on enabled lanes without link establishment
// - polynomial select: 00 PRBS7 (reset), 01 PRBS15, 10 PRBS31
// - lane enable register, one bit per physical lane, many at once
// - checker clear bit pulse wipes checker state, pass flags and counts
// - run bit rising edge starts test, writing zero stops counting
// - 24-bit pattern error limit held in three byte registers
// - pass register: one bit per lane, 1 pass, 0 fail
// - lane select views 24-bit saturating tally across three bytes
// - transport test compares selected converter and sample position
// - expected sample held across two byte registers
// - set compare enable, then pulse compare clear to restart
// - mismatch flag 0 on match, 1 once any mismatch seen
// - comma stream releases sync request and sets per-lane sync pass
// - repeated alignment mode releases sync after four commas
// - per-lane alignment pass register
// - link select bit views link 0 or 1, link 1 adds four
// - disparity counter counts wrong-disparity characters while not disabled and below the limit
// - one register sets lane and type select, reads selected count
// - one shared limit, each counter stops at it
// - three status registers report limit reached per error type
// - writes to status registers clear flag, disable or clear count
module lkt_link_test
  import lkt_pkg::*;
#(
  parameter int LANES = 8
)
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic [11:0] reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  input  wire logic [7:0]  prbs_rx_bit,
  input  wire logic [7:0]  char_valid,
  input  wire logic [7:0]  comma_seen,
  input  wire logic [7:0]  ilas_lane_ok,
  input  wire logic [7:0]  disp_err,
  input  wire logic [7:0]  nit_err,
  input  wire logic [7:0]  ucc_err,
  input  wire logic        links_enable,
  input  wire logic [7:0]  link_lane_enable,
  input  wire logic        tpl_sample_valid,
  input  wire logic [1:0]  tpl_conv_index,
  input  wire logic [1:0]  tpl_samp_index,
  input  wire logic [15:0] tpl_sample,
  input  wire logic        tpl_res_11bit,
  output logic             sync_request_out_n,
  output logic             ilas_test_mode
);
  logic [7:0]  link_page;
  logic [7:0]  prbs_lane_enable;
  logic [7:0]  prbs_ctl;
  logic [23:0] prbs_error_limit;
  logic [7:0]  tpl_ctl;
  logic [15:0] tpl_expected_value;
  logic [7:0]  err_view;
  logic [7:0]  test_cfg;
  logic [7:0]  shared_error_limit;
  logic [7:0]  prbs_lane_pass;
  logic        tpl_mismatch_flag;
  logic [7:0]  cgs_pass;
  logic [7:0]  ilas_pass;
  logic [2:0]  comma_cnt [LANES];
  logic [23:0] tally [LANES];
  logic [7:0]  count [3*LANES];
  logic [7:0]  reached [3];
  logic        run_prev;
  lkt_run_e    run_state;
  lkt_run_e    next_run_state;
  logic [2:0]  ctl_lane;
  logic [15:0] tpl_mask;
  logic [2:0]  view_lane;
  logic [23:0] sel_tally;
  logic [7:0]  next_rdata;

  lkt_prbs_if pif[LANES] ();
  lkt_cnt_if  cif[3*LANES] ();

  // logical lane seen through the link page
  function automatic logic [2:0] link_lane(input logic [2:0] lane, input logic sel);
    link_lane = sel ? lane + LINK1_OFFSET : lane;
  endfunction

  function automatic logic [7:0] link_view(input logic [7:0] f, input logic sel);
    link_view = sel ? {f[3:0], f[7:4]} : f;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // register writes

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      link_page          <= R_ZERO;
      prbs_lane_enable   <= R_ZERO;
      prbs_ctl           <= R_ZERO;
      prbs_error_limit   <= '0;
      tpl_ctl            <= R_ZERO;
      tpl_expected_value <= '0;
      err_view           <= R_ZERO;
      test_cfg           <= R_ZERO;
      shared_error_limit <= R_ERR_THR;
    end
    else if (reg_wr)
    begin
      unique case (reg_addr)
        A_LINK_PAGE: link_page <= reg_wdata;
        A_PRBS_EN:   prbs_lane_enable <= reg_wdata;
        A_PRBS_CTL:  prbs_ctl <= reg_wdata;
        A_PRBS_THR0: prbs_error_limit[7:0] <= reg_wdata;
        A_PRBS_THR1: prbs_error_limit[15:8] <= reg_wdata;
        A_PRBS_THR2: prbs_error_limit[23:16] <= reg_wdata;
        A_TPL_CTL:   tpl_ctl <= reg_wdata;
        A_TPL_EXP_A: tpl_expected_value[7:0] <= reg_wdata;
        A_TPL_EXP_B: tpl_expected_value[15:8] <= reg_wdata;
        A_ERR_VIEW:  err_view <= reg_wdata;
        A_TEST_CFG:  test_cfg <= reg_wdata;
        A_ERR_THR:   shared_error_limit <= reg_wdata;
        default:     ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pattern test run control

  always_comb
  begin
    next_run_state = run_state;
    unique case (run_state)
      LKT_IDLE:
        if (prbs_ctl[B_PRBS_RUN] && !run_prev)
          next_run_state = LKT_RUN;
      LKT_RUN:
        if (!prbs_ctl[B_PRBS_RUN] || prbs_ctl[B_PRBS_CLR])
          next_run_state = LKT_IDLE;
      default:
        next_run_state = LKT_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      run_state <= LKT_IDLE;
      run_prev  <= 1'b0;
    end
    else
    begin
      run_state <= next_run_state;
      run_prev  <= prbs_ctl[B_PRBS_RUN];
    end
  end

  // verdict taken when the run ends
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      prbs_lane_pass <= R_ZERO;
    else if (prbs_ctl[B_PRBS_CLR])
      prbs_lane_pass <= R_ZERO;
    else if ((run_state == LKT_RUN) && (next_run_state == LKT_IDLE))
    begin
      for (int i = 0; i < LANES; i++)
        prbs_lane_pass[i] <= prbs_lane_enable[i] && (tally[i] == '0);
    end
  end

  generate
    for (genvar g = 0; g < LANES; g++)
    begin : g_prbs
      assign pif[g].clear  = prbs_ctl[B_PRBS_CLR];
      assign pif[g].run    = (run_state == LKT_RUN);
      assign pif[g].poly   = prbs_ctl[F_POLY_LO +: 2];
      assign pif[g].en     = prbs_lane_enable[g];
      assign pif[g].rx_bit = prbs_rx_bit[g];
      assign tally[g]      = pif[g].tally;
      lkt_prbs_checker u_chk
      (
        .clk     (clk),
        .reset_n (reset_n),
        .p       (pif[g])
      );
    end
  endgenerate

  assign sel_tally = tally[prbs_ctl[F_PLANE_LO +: 3]];

  ////////////////////////////////////////////////////////////////////////////
  // transport layer sample compare

  assign tpl_mask = tpl_res_11bit ? {{11{1'b1}}, {TPL_RES11_LO{1'b0}}} : 16'hFFFF;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      tpl_mismatch_flag <= 1'b0;
    else if (tpl_ctl[B_TPL_CLR] || !tpl_ctl[B_TPL_EN])
      tpl_mismatch_flag <= 1'b0;
    else if (tpl_sample_valid
             && (tpl_conv_index == tpl_ctl[F_CONV_LO +: 2])
             && (tpl_samp_index == tpl_ctl[F_SAMP_LO +: 2])
             && ((tpl_sample & tpl_mask) != (tpl_expected_value & tpl_mask)))
      tpl_mismatch_flag <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // code group sync and lane alignment

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cgs_pass  <= R_ZERO;
      ilas_pass <= R_ZERO;
      for (int i = 0; i < LANES; i++)
        comma_cnt[i] <= '0;
    end
    else
    begin
      for (int i = 0; i < LANES; i++)
      begin
        if (!links_enable || !link_lane_enable[i])
        begin
          comma_cnt[i] <= '0;
          cgs_pass[i]  <= 1'b0;
          ilas_pass[i] <= 1'b0;
        end
        else
        begin
          if (char_valid[i] && !cgs_pass[i])
            comma_cnt[i] <= comma_seen[i] ? comma_cnt[i] + 3'h1 : 3'h0;
          if (comma_cnt[i] == CGS_COMMAS)
            cgs_pass[i] <= 1'b1;
          if (ilas_lane_ok[i] && cgs_pass[i])
            ilas_pass[i] <= 1'b1;
        end
      end
    end
  end

  // request held low until every enabled lane has its commas
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      sync_request_out_n <= 1'b0;
    else
      sync_request_out_n <= links_enable
                            && ((cgs_pass & link_lane_enable) == link_lane_enable);
  end

  assign ilas_test_mode = test_cfg[B_ILAS_TEST];

  ////////////////////////////////////////////////////////////////////////////
  // character error counters

  assign ctl_lane = link_lane(reg_wdata[2:0], link_page[B_LINK_SEL]);

  generate
    for (genvar t = 0; t < 3; t++)
    begin : g_type
      for (genvar l = 0; l < LANES; l++)
      begin : g_lane
        localparam int K = t * LANES + l;
        assign cif[K].err = (t == 0) ? disp_err[l] : (t == 1) ? nit_err[l] : ucc_err[l];
        assign cif[K].thr = shared_error_limit;
        assign cif[K].sel = reg_wr && (reg_addr == A_OVER_DISP + 12'(t))
                            && (ctl_lane == 3'(l));
        assign cif[K].rst_irq = reg_wdata[B_RST_IRQ];
        assign cif[K].dis     = reg_wdata[B_DIS_CNT];
        assign cif[K].rst_cnt = reg_wdata[B_RST_CNT];
        assign count[K]      = cif[K].count;
        assign reached[t][l] = cif[K].reached;
        lkt_err_counter u_cnt
        (
          .clk     (clk),
          .reset_n (reset_n),
          .c       (cif[K])
        );
      end
    end
  endgenerate

  assign view_lane = link_lane(err_view[F_VLANE_LO +: 3], link_page[B_LINK_SEL]);

  ////////////////////////////////////////////////////////////////////////////
  // register reads

  always_comb
  begin
    next_rdata = R_ZERO;
    unique case (reg_addr)
      A_LINK_PAGE: next_rdata = link_page;
      A_PRBS_EN:   next_rdata = prbs_lane_enable;
      A_PRBS_CTL:  next_rdata = prbs_ctl;
      A_PRBS_THR0: next_rdata = prbs_error_limit[7:0];
      A_PRBS_THR1: next_rdata = prbs_error_limit[15:8];
      A_PRBS_THR2: next_rdata = prbs_error_limit[23:16];
      A_PRBS_CNT0: next_rdata = sel_tally[7:0];
      A_PRBS_CNT1: next_rdata = sel_tally[15:8];
      A_PRBS_CNT2: next_rdata = sel_tally[23:16];
      A_PRBS_PASS: next_rdata = prbs_lane_pass;
      A_TPL_CTL:   next_rdata = tpl_ctl;
      A_TPL_EXP_A: next_rdata = tpl_expected_value[7:0];
      A_TPL_EXP_B: next_rdata = tpl_expected_value[15:8];
      A_TPL_FAIL:  next_rdata = {7'h00, tpl_mismatch_flag};
      A_ERR_VIEW:
        if (err_view[1:0] != 2'h3)
          next_rdata = count[int'(err_view[1:0]) * LANES + int'(view_lane)];
      A_OVER_DISP: next_rdata = link_view(reached[LKT_CNT_DISP], link_page[B_LINK_SEL]);
      A_OVER_NIT:  next_rdata = link_view(reached[LKT_CNT_NIT], link_page[B_LINK_SEL]);
      A_OVER_UCC:  next_rdata = link_view(reached[LKT_CNT_UCC], link_page[B_LINK_SEL]);
      A_CGS_PASS:  next_rdata = link_view(cgs_pass, link_page[B_LINK_SEL]);
      A_ILAS_PASS: next_rdata = link_view(ilas_pass, link_page[B_LINK_SEL]);
      A_TEST_CFG:  next_rdata = test_cfg;
      A_ERR_THR:   next_rdata = shared_error_limit;
      default:     next_rdata = R_ZERO;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      reg_rdata <= R_ZERO;
    else if (reg_rd)
      reg_rdata <= next_rdata;
  end
endmodule

// File: lkt_link_test_asserts.sv
// concurrent checks on the link test register port and sync output
`timescale 1ns/1ps
module lkt_link_test_chk
  import lkt_pkg::*;
#(
  parameter int LANES = 8
)
(
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic [11:0] reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  input wire logic [7:0]  char_valid,
  input wire logic [7:0]  comma_seen,
  input wire logic [7:0]  disp_err,
  input wire logic [7:0]  nit_err,
  input wire logic [7:0]  ucc_err,
  input wire logic        links_enable,
  input wire logic [7:0]  link_lane_enable,
  input wire logic        sync_request_out_n,
  input wire logic        ilas_test_mode
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic       tpl_en;
  logic       prbs_clr;
  logic       err_seen;
  logic       thr_dropped;
  logic [7:0] thr;
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
      tpl_en <= 1'b0;
    else if (reg_wr && reg_addr == A_TPL_CTL)
      tpl_en <= reg_wdata[B_TPL_EN];
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
      prbs_clr <= 1'b0;
    else if (reg_wr && reg_addr == A_PRBS_CTL)
      prbs_clr <= reg_wdata[B_PRBS_CLR];
  // a lowered limit may leave counts above it
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
    begin
      thr         <= R_ERR_THR;
      err_seen    <= 1'b0;
      thr_dropped <= 1'b0;
    end
    else
    begin
      err_seen <= err_seen | (|{disp_err, nit_err, ucc_err});
      if (reg_wr && reg_addr == A_ERR_THR)
      begin
        thr         <= reg_wdata;
        thr_dropped <= thr_dropped | (err_seen && reg_wdata < thr);
      end
    end
  ////////////////////////////////////////////////////////////////////////////
  sequence s_wr_rd(logic [11:0] a);
    reg_wr && reg_addr == a ##1 reg_rd && reg_addr == a;
  endsequence
  sequence s_commas;
    links_enable && link_lane_enable != 8'h00 && $stable(link_lane_enable)
      && (char_valid & comma_seen & link_lane_enable) == link_lane_enable;
  endsequence
  AST_RDATA_HOLD: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  AST_LANE_EN_RB: assert property (s_wr_rd(A_PRBS_EN) |=> reg_rdata == $past(reg_wdata, 2))
    else $error("lane enable readback wrong");
  AST_ILAS_MODE: assert property ((reg_wr && reg_addr == A_TEST_CFG)
    |=> ilas_test_mode == $past(reg_wdata[B_ILAS_TEST]))
    else $error("alignment test mode output wrong");
  AST_SYNC_OFF: assert property (!links_enable |=> !sync_request_out_n)
    else $error("sync released with links off");
  AST_SYNC_REL: assert property (s_commas [*5] |-> ##2 sync_request_out_n)
    else $error("sync not released after commas");
  AST_TPL_OFF: assert property ((!tpl_en) [*3] ##0 (reg_rd && reg_addr == A_TPL_FAIL)
    |=> reg_rdata[0] == 1'b0)
    else $error("sample fail flag set while compare off");
  AST_PRBS_CLR: assert property (prbs_clr [*3] ##0
    (reg_rd && reg_addr >= A_PRBS_CNT0 && reg_addr <= A_PRBS_PASS) |=> reg_rdata == 8'h00)
    else $error("pattern results not cleared");
  AST_CNT_LIMIT: assert property ((reg_rd && reg_addr == A_ERR_VIEW && !thr_dropped)
    |=> reg_rdata <= $past(thr))
    else $error("error count above limit");
endmodule
bind lkt_link_test lkt_link_test_chk #(.LANES(LANES)) u_chk
(
  .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .char_valid(char_valid),
  .comma_seen(comma_seen), .disp_err(disp_err), .nit_err(nit_err), .ucc_err(ucc_err),
  .links_enable(links_enable), .link_lane_enable(link_lane_enable),
  .sync_request_out_n(sync_request_out_n), .ilas_test_mode(ilas_test_mode)
);

// File: lkt_tx_model.sv
// far-side transmitter model: pattern, commas, alignment, samples
`timescale 1ns/1ps
module lkt_tx_model
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic [1:0]  poly,
  input  wire logic [7:0]  bad_lanes,
  input  wire logic        tpl_on,
  input  wire logic        sync_request_out_n,
  output logic      [7:0]  prbs_rx_bit,
  output logic      [7:0]  char_valid,
  output logic      [7:0]  comma_seen,
  output logic      [7:0]  ilas_lane_ok,
  output logic             tpl_sample_valid,
  output logic      [1:0]  tpl_conv_index,
  output logic      [1:0]  tpl_samp_index,
  output logic      [15:0] tpl_sample
);
  logic [30:0] lfsr;
  logic        fb;
  logic [1:0]  pos;
  always_comb
    case (poly)
      2'h1:    fb = lfsr[14] ^ lfsr[13];
      2'h2:    fb = lfsr[30] ^ lfsr[27];
      default: fb = lfsr[6] ^ lfsr[5];
    endcase
  // pattern free-runs so it is present before any run starts
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
      lfsr <= 31'h1;
    else
      lfsr <= {lfsr[29:0], fb};
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
      pos <= 2'h0;
    else
      pos <= pos + 2'h1;
  // inverted lanes model a broken link
  assign prbs_rx_bit = {8{fb}} ^ bad_lanes;
  assign char_valid = 8'hFF;
  // commas while sync is requested, then repeated alignment sequences
  assign comma_seen = sync_request_out_n ? 8'h00 : 8'hFF;
  assign ilas_lane_ok = (sync_request_out_n && pos == 2'h3) ? 8'hFF : 8'h00;
  // one unique value per position, repeated
  assign tpl_sample_valid = tpl_on;
  assign tpl_conv_index = {1'b0, pos[1]};
  assign tpl_samp_index = {1'b0, pos[0]};
  assign tpl_sample = 16'hA5C0 + {14'h0, pos};
endmodule

// File: testbench.sv
// self-checking bench for the link test and error monitor
`timescale 1ns/1ps
module testbench
  import lkt_pkg::*;
;
  logic        clk, reset_n, reg_wr, reg_rd, links_enable, tpl_on, res11;
  logic        tpl_sample_valid, sync_request_out_n, ilas_test_mode;
  logic [11:0] reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, prbs_rx_bit, char_valid, comma_seen, ilas_lane_ok;
  logic [7:0]  link_lane_enable, bad_lanes, c;
  logic [7:0]  err_v [3];
  logic [1:0]  poly, tpl_conv_index, tpl_samp_index;
  logic [15:0] tpl_sample, e;
  logic [23:0] t0, t1;
  int          errors, checks;
  lkt_link_test u_dut
  (
    .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .prbs_rx_bit(prbs_rx_bit),
    .char_valid(char_valid), .comma_seen(comma_seen), .ilas_lane_ok(ilas_lane_ok),
    .disp_err(err_v[0]), .nit_err(err_v[1]), .ucc_err(err_v[2]),
    .links_enable(links_enable), .link_lane_enable(link_lane_enable),
    .tpl_sample_valid(tpl_sample_valid), .tpl_conv_index(tpl_conv_index),
    .tpl_samp_index(tpl_samp_index), .tpl_sample(tpl_sample), .tpl_res_11bit(res11),
    .sync_request_out_n(sync_request_out_n), .ilas_test_mode(ilas_test_mode)
  );
  lkt_tx_model u_tx
  (
    .clk(clk), .reset_n(reset_n), .poly(poly), .bad_lanes(bad_lanes), .tpl_on(tpl_on),
    .sync_request_out_n(sync_request_out_n), .prbs_rx_bit(prbs_rx_bit),
    .char_valid(char_valid), .comma_seen(comma_seen), .ilas_lane_ok(ilas_lane_ok),
    .tpl_sample_valid(tpl_sample_valid), .tpl_conv_index(tpl_conv_index),
    .tpl_samp_index(tpl_samp_index), .tpl_sample(tpl_sample)
  );
  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    if (errors == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  // strobes stay up until the next call, so calls chain back to back
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    reg_rd = 1'b0;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
  endtask
  task automatic rd(input logic [11:0] a, output logic [7:0] q);
    reg_wr = 1'b0;
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    q = reg_rdata;
  endtask
  task automatic idle(input int n);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (n) @(negedge clk);
  endtask
  task automatic rc(input logic [11:0] a, input logic [7:0] exp);
    logic [7:0] q;
    rd(a, q);
    chk(q, exp);
  endtask
  task automatic tally(output logic [23:0] n);
    rd(A_PRBS_CNT0, n[7:0]);
    rd(A_PRBS_CNT1, n[15:8]);
    rd(A_PRBS_CNT2, n[23:16]);
  endtask
  task automatic pulse(input int t, input int n);
    idle(0);
    err_v[t] = 8'h02;
    repeat (n) @(negedge clk);
    err_v[t] = 8'h00;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial
  begin
    #2000000;
    errors++;
    end_of_test();
  end
  initial
  begin
    reg_addr = 12'h000;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    links_enable = 1'b0;
    link_lane_enable = 8'h0F;
    bad_lanes = 8'h04;
    poly = 2'h0;
    tpl_on = 1'b0;
    res11 = 1'b0;
    err_v = '{8'h00, 8'h00, 8'h00};
    reset_n = 1'b0;
    repeat (20) @(negedge clk);
    reset_n = 1'b1;
    rc(A_ERR_THR, R_ERR_THR);
    rc(A_PRBS_CTL, 8'h00);
    rc(12'h001, 8'h00);
    for (int i = 0; i < 3; i++)
    begin
      wr(A_PRBS_THR0 + 12'(i), 8'h5A + 8'(i));
      rc(A_PRBS_THR0 + 12'(i), 8'h5A + 8'(i));
    end
    // every polynomial; lane 2 corrupted, lane 5 not enabled
    for (int p = 0; p < 3; p++)
    begin
      poly = 2'(p);
      wr(A_PRBS_EN, 8'hDF);
      rc(A_PRBS_EN, 8'hDF);
      wr(A_PRBS_CTL, {4'h2, poly, 2'b01});
      idle(1);
      rc(A_PRBS_PASS, 8'h00);
      tally(t0);
      chk(t0[7:0] | t0[15:8] | t0[23:16], 8'h00);
      wr(A_PRBS_CTL, {4'h2, poly, 2'b00});
      wr(A_PRBS_CTL, {4'h2, poly, 2'b10});
      idle(300);
      wr(A_PRBS_CTL, {4'h2, poly, 2'b00});
      idle(1);
      rc(A_PRBS_PASS, 8'hDB);
      tally(t0);
      idle(20);
      tally(t1);
      chk(8'(t0 == t1), 8'h01);
      chk(8'(t0 != 24'h0), 8'h01);
      wr(A_PRBS_CTL, {4'h0, poly, 2'b00});
      rc(A_PRBS_CTL, {4'h0, poly, 2'b00});
      tally(t0);
      chk(t0[7:0] | t0[15:8] | t0[23:16], 8'h00);
    end
    wr(A_TEST_CFG, 8'h80);
    rc(A_TEST_CFG, 8'h80);
    chk({7'h0, ilas_test_mode}, 8'h01);
    links_enable = 1'b1;
    idle(20);
    chk({7'h0, sync_request_out_n}, 8'h01);
    rc(A_CGS_PASS, 8'h0F);
    rc(A_ILAS_PASS, 8'h0F);
    wr(A_LINK_PAGE, 8'h04);
    rc(A_CGS_PASS, 8'hF0);
    wr(A_LINK_PAGE, 8'h00);
    // pass 4 wrong at position 0; pass 5 differs only below the 11-bit field
    tpl_on = 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      res11 = i > 4;
      e = 16'hA5C0 + 16'(i % 4) + 16'(i > 3);
      c = {3'h0, i[0], 1'b0, i[1], 2'b01};
      wr(A_TPL_EXP_A, e[7:0]);
      wr(A_TPL_EXP_B, e[15:8]);
      wr(A_TPL_CTL, c);
      wr(A_TPL_CTL, c | 8'h02);
      wr(A_TPL_CTL, c);
      idle(12);
      rc(A_TPL_FAIL, {7'h0, i == 4});
    end
    wr(A_TPL_CTL, 8'h00);
    idle(2);
    rc(A_TPL_FAIL, 8'h00);
    wr(A_ERR_THR, 8'h03);
    for (int t = 0; t < 3; t++)
    begin
      wr(A_ERR_VIEW, 8'h10 + 8'(t));
      pulse(t, 5);
      rc(A_ERR_VIEW, 8'h03);
      rc(A_OVER_DISP + 12'(t), 8'h02);
      wr(A_OVER_DISP + 12'(t), 8'h21);
      rc(A_ERR_VIEW, 8'h00);
      wr(A_OVER_DISP + 12'(t), 8'h81);
      rc(A_OVER_DISP + 12'(t), 8'h00);
      wr(A_OVER_DISP + 12'(t), 8'h41);
      pulse(t, 2);
      rc(A_ERR_VIEW, 8'h00);
      wr(A_OVER_DISP + 12'(t), 8'h01);
      pulse(t, 1);
      rc(A_ERR_VIEW, 8'h01);
    end
    idle(2);
    end_of_test();
  end
endmodule
